//--- design/spim_pkg.sv
/*
 * Constants, state encodings and shared helpers of the serial port.
 * Assumes the CPU side reaches the three registers through plain strobe ports.
 */
`default_nettype none

package spim_pkg;

    localparam int DW = 8;

    // control register fields
    localparam int CR_IRQ_EN_BIT = 7;
    localparam int CR_PORT_EN_BIT = 6;
    localparam int CR_RATE2_BIT = 5;
    localparam int CR_MASTER_BIT = 4;
    localparam int CR_CLOCK_POLARITY_BIT = 3;
    localparam int CR_CLOCK_PHASE_BIT = 2;
    localparam int CR_RATE1_BIT = 1;
    localparam int CR_RATE0_BIT = 0;

    // control/status register fields
    localparam int CSR_DONE_BIT = 7;
    localparam int CSR_WRITE_COLLISION_FLAG_BIT = 6;
    localparam int CSR_OVR_BIT = 5;
    localparam int CSR_MODE_FAULT_FLAG_BIT = 4;
    localparam int CSR_SSM_BIT = 1;
    localparam int CSR_SSI_BIT = 0;

    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [2:0] RATE_RESET = 3'h0;

    // rate codes and half periods of sck, in clk cycles minus one
    localparam logic [2:0] RATE_DIV4 = 3'h4;
    localparam logic [2:0] RATE_DIV8 = 3'h0;
    localparam logic [2:0] RATE_DIV16 = 3'h1;
    localparam logic [2:0] RATE_DIV32 = 3'h6;
    localparam logic [2:0] RATE_DIV64 = 3'h2;
    localparam logic [6:0] HALF_DIV4 = 7'h01;
    localparam logic [6:0] HALF_DIV8 = 7'h03;
    localparam logic [6:0] HALF_DIV16 = 7'h07;
    localparam logic [6:0] HALF_DIV32 = 7'h0f;
    localparam logic [6:0] HALF_DIV64 = 7'h1f;
    localparam logic [6:0] HALF_DIV128 = 7'h3f;
    localparam logic [6:0] HALF_ZERO = 7'h00;

    // sixteen sck transitions per byte
    localparam logic [3:0] FIRST_EDGE = 4'h0;
    localparam logic [3:0] LAST_EDGE = 4'hf;

    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_AW = 5;

    typedef enum logic [2:0] {
        M_IDLE = 3'b001,
        M_HOLD = 3'b010,
        M_RUN = 3'b100
    } spim_mstate_t;

    // unused codes fall back to the slowest rate
    function automatic logic [6:0] spim_half_count(input logic [2:0] rate);
        case (rate)
            RATE_DIV4: return HALF_DIV4;
            RATE_DIV8: return HALF_DIV8;
            RATE_DIV16: return HALF_DIV16;
            RATE_DIV32: return HALF_DIV32;
            RATE_DIV64: return HALF_DIV64;
            default: return HALF_DIV128;
        endcase
    endfunction : spim_half_count

    // one sck transition: returns {shift register, captured bit}
    function automatic logic [8:0] spim_step(input logic [7:0] sr, input logic cap,
                                             input logic [3:0] e, input logic clock_phase,
                                             input logic din);
        logic [7:0] s;
        logic c;
        s = sr;
        c = cap;
        if (e[0] == clock_phase)
        begin
            c = din;
            if (clock_phase && (e == LAST_EDGE))
            begin
                s = {sr[6:0], din};
            end
        end
        else if (e != FIRST_EDGE)
        begin
            s = {sr[6:0], cap};
        end
        return {s, c};
    endfunction : spim_step

endpackage : spim_pkg

`default_nettype wire

//--- design/spim_sync.sv
/*
 * Two-flop synchroniser for a group of pin inputs.
 * Assumes each bit changes slowly relative to clk; no bus coherence is given.
 */
`default_nettype none

module spim_sync
    import spim_pkg::*;
#(
    parameter int W = 4
)
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // pins in, synchronised out
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } spim_sync_st_t;

    spim_sync_st_t st_ff;
    spim_sync_st_t nxt_st;

    always_comb
    begin
        nxt_st.s1 = din;
        nxt_st.s2 = st_ff.s1;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign dout = st_ff.s2;

endmodule : spim_sync

`default_nettype wire

//--- design/spim_fifo.sv
/*
 * Received-byte FIFO with registered read data and valid/ready on both sides.
 * Assumes a single clock; the output stage holds one word beyond DEPTH.
 */
`default_nettype none

module spim_fifo
    import spim_pkg::*;
#(
    parameter int W = 8,
    parameter int DEPTH = 32,
    parameter int AW = 5
)
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // filling side
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // draining side
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);

    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
    localparam logic [AW:0] EMPTY_COUNT = '0;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
        logic [W-1:0] out_data;
        logic out_valid;
    } spim_fifo_st_t;

    spim_fifo_st_t st_ff;
    spim_fifo_st_t nxt_st;
    logic push;
    logic load;

    always_comb
    begin
        nxt_st = st_ff;
        push = in_valid && (st_ff.count != FULL_COUNT);
        load = (st_ff.count != EMPTY_COUNT) && (!st_ff.out_valid || out_ready);
        if (push)
        begin
            nxt_st.mem[st_ff.wr_ptr] = in_data;
            nxt_st.wr_ptr = st_ff.wr_ptr + 1'b1;
        end
        if (load)
        begin
            nxt_st.out_data = st_ff.mem[st_ff.rd_ptr];
            nxt_st.rd_ptr = st_ff.rd_ptr + 1'b1;
            nxt_st.out_valid = 1'b1;
        end
        else if (out_ready)
        begin
            nxt_st.out_valid = 1'b0;
        end
        if (push && !load)
        begin
            nxt_st.count = st_ff.count + 1'b1;
        end
        else if (load && !push)
        begin
            nxt_st.count = st_ff.count - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign in_ready = (st_ff.count != FULL_COUNT);
    assign out_valid = st_ff.out_valid;
    assign out_data = st_ff.out_data;

endmodule : spim_fifo

`default_nettype wire

//--- design/spim_port.sv
/*
 * Master/slave synchronous serial port with its three CPU registers.
 * Assumes CPU access strobes are one-cycle pulses on clk; all pins are async.
 */
`default_nettype none

module spim_port
    import spim_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // control register access
    input wire logic cr_wr,
    input wire logic [7:0] cr_wdata,
    output logic [7:0] cr_rdata,
    // control/status register access
    input wire logic csr_rd,
    input wire logic csr_wr,
    input wire logic [7:0] csr_wdata,
    output logic [7:0] csr_rdata,
    // data register access
    input wire logic dr_rd,
    input wire logic dr_wr,
    input wire logic [7:0] dr_wdata,
    output logic [7:0] dr_rdata,
    // cpu interrupt
    input wire logic cpu_irq_mask,
    output logic irq_req,
    // serial pins
    input wire logic ss_n_pin,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe,
    // received byte stream
    output logic rx_valid,
    output logic [7:0] rx_data,
    input wire logic rx_ready
);

    typedef struct packed {
        logic irq_en;
        logic port_enable;
        logic [2:0] rate;
        logic master_select;
        logic clock_polarity;
        logic clock_phase;
        logic tdf;
        logic write_collision_flag;
        logic overrun_flag;
        logic mode_fault_flag;
        logic soft_select_manage;
        logic soft_select_level;
        logic tdf_armed;
        logic tdf_seen_rd;
        logic write_collision_flag_armed;
        logic mode_fault_flag_armed;
        logic [7:0] sr;
        logic cap;
        logic [7:0] rxbuf;
        logic [3:0] edge_cnt;
        logic [6:0] half_cnt;
        spim_mstate_t mstate;
        logic sck_out;
        logic sck_prev;
        logic sck_oe;
        logic miso_oe;
        logic irq;
        logic push;
        logic [7:0] push_data;
    } spim_port_st_t;

    spim_port_st_t st_ff;
    spim_port_st_t nxt_st;

    logic [3:0] pins_s;
    logic ss_s;
    logic sck_s;
    logic mosi_s;
    logic miso_s;
    logic fifo_ready;
    logic ss_int;
    logic busy;
    logic done_w;
    logic [7:0] rx_byte;
    logic [8:0] step;

    ////////////////////////////////////////////////////////////////////////////

    spim_sync #(
        .W(4)
    ) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .din({ss_n_pin, sck_in, mosi_in, miso_in}),
        .dout(pins_s)
    );

    assign ss_s = pins_s[3];
    assign sck_s = pins_s[2];
    assign mosi_s = pins_s[1];
    assign miso_s = pins_s[0];

    // stream copy of each byte with room in the fifo; a full fifo stalls master starts and drops slave bytes
    spim_fifo #(
        .W(DW),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .arst_n(arst_n),
        .in_valid(st_ff.push),
        .in_data(st_ff.push_data),
        .in_ready(fifo_ready),
        .out_valid(rx_valid),
        .out_data(rx_data),
        .out_ready(rx_ready)
    );

    ////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.push = 1'b0;
        done_w = 1'b0;
        rx_byte = st_ff.sr;
        step = {st_ff.sr, st_ff.cap};
        ss_int = st_ff.soft_select_manage ? st_ff.soft_select_level : ss_s;
        // phase zero slave is busy for as long as it is selected
        busy = (st_ff.mstate != M_IDLE)
            || (st_ff.port_enable && !st_ff.master_select && !ss_int
                && (!st_ff.clock_phase || (st_ff.edge_cnt != FIRST_EDGE)));

        // control register write
        if (cr_wr)
        begin
            nxt_st.irq_en = cr_wdata[CR_IRQ_EN_BIT];
            nxt_st.rate = {cr_wdata[CR_RATE2_BIT], cr_wdata[CR_RATE1_BIT],
                           cr_wdata[CR_RATE0_BIT]};
            nxt_st.clock_polarity = cr_wdata[CR_CLOCK_POLARITY_BIT];
            nxt_st.clock_phase = cr_wdata[CR_CLOCK_PHASE_BIT];
            // a pending fault only lets these bits be cleared
            nxt_st.port_enable = cr_wdata[CR_PORT_EN_BIT]
                && (st_ff.port_enable || !st_ff.mode_fault_flag || st_ff.mode_fault_flag_armed);
            nxt_st.master_select = cr_wdata[CR_MASTER_BIT]
                && (st_ff.master_select || !st_ff.mode_fault_flag || st_ff.mode_fault_flag_armed);
            if (st_ff.mode_fault_flag_armed)
            begin
                nxt_st.mode_fault_flag = 1'b0;
                nxt_st.mode_fault_flag_armed = 1'b0;
            end
        end

        // control/status register access
        if (csr_wr)
        begin
            nxt_st.soft_select_manage = csr_wdata[CSR_SSM_BIT];
            nxt_st.soft_select_level = csr_wdata[CSR_SSI_BIT];
        end
        if ((csr_wr || csr_rd) && st_ff.tdf)
        begin
            nxt_st.tdf_armed = 1'b1;
        end
        if (csr_rd)
        begin
            nxt_st.overrun_flag = 1'b0;
            nxt_st.write_collision_flag_armed = 1'b1;
            if (st_ff.tdf)
            begin
                nxt_st.tdf_seen_rd = 1'b1;
            end
            if (st_ff.mode_fault_flag)
            begin
                nxt_st.mode_fault_flag_armed = 1'b1;
            end
        end

        // data register access
        if (dr_rd || dr_wr)
        begin
            if (st_ff.tdf_armed)
            begin
                nxt_st.tdf = 1'b0;
                nxt_st.tdf_armed = 1'b0;
                nxt_st.tdf_seen_rd = 1'b0;
            end
            if (st_ff.write_collision_flag_armed)
            begin
                nxt_st.write_collision_flag = 1'b0;
                nxt_st.write_collision_flag_armed = 1'b0;
            end
        end
        if (dr_wr && (!st_ff.tdf || st_ff.tdf_seen_rd))
        begin
            if (busy)
            begin
                nxt_st.write_collision_flag = 1'b1;
                nxt_st.write_collision_flag_armed = 1'b0;
            end
            else
            begin
                nxt_st.sr = dr_wdata;
                if (st_ff.port_enable && st_ff.master_select)
                begin
                    nxt_st.mstate = M_HOLD;
                    nxt_st.edge_cnt = FIRST_EDGE;
                    nxt_st.half_cnt = spim_half_count(st_ff.rate);
                    nxt_st.sck_out = st_ff.clock_polarity;
                end
            end
        end

        // master clock engine
        case (st_ff.mstate)
            M_IDLE:
            begin
                nxt_st.sck_out = st_ff.clock_polarity;
            end
            M_HOLD:
            begin
                if (fifo_ready && !st_ff.push)
                begin
                    nxt_st.mstate = M_RUN;
                end
            end
            M_RUN:
            begin
                if (st_ff.half_cnt == HALF_ZERO)
                begin
                    nxt_st.half_cnt = spim_half_count(st_ff.rate);
                    nxt_st.sck_out = !st_ff.sck_out;
                    step = spim_step(st_ff.sr, st_ff.cap, st_ff.edge_cnt, st_ff.clock_phase, miso_s);
                    nxt_st.sr = step[8:1];
                    nxt_st.cap = step[0];
                    nxt_st.edge_cnt = st_ff.edge_cnt + 1'b1;
                    if (st_ff.edge_cnt == LAST_EDGE)
                    begin
                        nxt_st.mstate = M_IDLE;
                        done_w = 1'b1;
                        rx_byte = step[8:1];
                        // phase one: mosi must not move on its own final capture edge
                        nxt_st.sr = st_ff.clock_phase ? st_ff.sr : step[8:1];
                    end
                end
                else
                begin
                    nxt_st.half_cnt = st_ff.half_cnt - 1'b1;
                end
            end
            default:
            begin
                nxt_st.mstate = M_IDLE;
            end
        endcase

        // slave engine, clocked by edges of the synchronised sck
        nxt_st.sck_prev = sck_s;
        if (st_ff.port_enable && !st_ff.master_select && !ss_int)
        begin
            if (sck_s != st_ff.sck_prev)
            begin
                step = spim_step(st_ff.sr, st_ff.cap, st_ff.edge_cnt, st_ff.clock_phase, mosi_s);
                nxt_st.sr = step[8:1];
                nxt_st.cap = step[0];
                nxt_st.edge_cnt = st_ff.edge_cnt + 1'b1;
                if (st_ff.edge_cnt == LAST_EDGE)
                begin
                    done_w = 1'b1;
                    rx_byte = step[8:1];
                end
            end
        end
        else if (st_ff.mstate == M_IDLE)
        begin
            // deselect resynchronises the bit count for the next byte
            nxt_st.edge_cnt = FIRST_EDGE;
        end

        // byte completion; a set beats a same-cycle clear
        if (done_w)
        begin
            nxt_st.push = 1'b1;
            nxt_st.push_data = rx_byte;
            nxt_st.tdf = 1'b1;
            nxt_st.tdf_armed = 1'b0;
            nxt_st.tdf_seen_rd = 1'b0;
            if (st_ff.tdf)
            begin
                nxt_st.overrun_flag = 1'b1;
            end
            else
            begin
                nxt_st.rxbuf = rx_byte;
            end
        end

        // mode fault overrides same-cycle writes of enable, master, the fault flag and a master start
        if (st_ff.master_select && !ss_int)
        begin
            nxt_st.mode_fault_flag = 1'b1;
            nxt_st.mode_fault_flag_armed = 1'b0;
            nxt_st.port_enable = 1'b0;
            nxt_st.master_select = 1'b0;
            nxt_st.mstate = M_IDLE;
        end

        nxt_st.sck_oe = nxt_st.port_enable && nxt_st.master_select;
        nxt_st.miso_oe = nxt_st.port_enable && !nxt_st.master_select && !ss_int;
        nxt_st.irq = nxt_st.irq_en && !cpu_irq_mask
            && (nxt_st.tdf || nxt_st.mode_fault_flag || nxt_st.overrun_flag);
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_ff <= '0;
            st_ff.mstate <= M_IDLE;
            st_ff.rate <= RATE_RESET;
            st_ff.sr <= DATA_RESET;
            st_ff.rxbuf <= DATA_RESET;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    assign cr_rdata = {st_ff.irq_en, st_ff.port_enable, st_ff.rate[2], st_ff.master_select,
                       st_ff.clock_polarity, st_ff.clock_phase, st_ff.rate[1:0]};
    assign csr_rdata = {st_ff.tdf, st_ff.write_collision_flag, st_ff.overrun_flag, st_ff.mode_fault_flag,
                        2'h0, st_ff.soft_select_manage, st_ff.soft_select_level};
    assign dr_rdata = st_ff.rxbuf;
    assign irq_req = st_ff.irq;
    assign sck_out = st_ff.sck_out;
    assign sck_oe = st_ff.sck_oe;
    assign mosi_out = st_ff.sr[7];
    assign mosi_oe = st_ff.sck_oe;
    assign miso_out = st_ff.sr[7];
    assign miso_oe = st_ff.miso_oe;

    ////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    mode_fault_flag_force_a: assert property (
        (st_ff.master_select && !ss_int) |=> (st_ff.mode_fault_flag && !st_ff.master_select && !st_ff.port_enable && !sck_oe))
        else $error("mode fault did not drop master and enable");

    mode_fault_flag_refuse_a: assert property (
        (cr_wr && cr_wdata[CR_PORT_EN_BIT] && st_ff.mode_fault_flag && !st_ff.mode_fault_flag_armed && !st_ff.port_enable)
        |=> !st_ff.port_enable)
        else $error("enable set while mode fault pending");

    ssm_ignore_a: assert property (
        (st_ff.soft_select_manage && st_ff.soft_select_level && st_ff.master_select && !st_ff.mode_fault_flag) |=> !st_ff.mode_fault_flag)
        else $error("pin select used under software management");

    ovr_set_a: assert property (
        (done_w && st_ff.tdf) |=> (st_ff.overrun_flag && $stable(st_ff.rxbuf)))
        else $error("overrun not flagged or buffer overwritten");

    ovr_clear_a: assert property (
        (csr_rd && !done_w) |=> !st_ff.overrun_flag)
        else $error("overrun survived a status read");

    write_collision_flag_set_a: assert property (
        (dr_wr && busy && (!st_ff.tdf || st_ff.tdf_seen_rd) && (st_ff.mstate != M_HOLD))
        |=> (st_ff.write_collision_flag && (st_ff.mstate != M_HOLD)))
        else $error("write collision missed");

    dr_inhibit_a: assert property (
        (dr_wr && st_ff.tdf && !st_ff.tdf_seen_rd && (st_ff.mstate == M_IDLE) && !busy)
        |=> (st_ff.mstate == M_IDLE))
        else $error("data write accepted while done flag set");

    done_clear_a: assert property (
        (st_ff.tdf_armed && dr_rd && !done_w) |=> !st_ff.tdf)
        else $error("done flag not cleared by sequence");

    done_flag_a: assert property (
        ((st_ff.mstate == M_RUN) && (st_ff.half_cnt == HALF_ZERO)
         && (st_ff.edge_cnt == LAST_EDGE)) |=> (st_ff.tdf && st_ff.push))
        else $error("done flag not set at byte end");

    irq_gate_a: assert property (
        (st_ff.irq_en && !cpu_irq_mask && st_ff.tdf)
        |=> (irq_req || !st_ff.irq_en || !st_ff.tdf))
        else $error("interrupt request missing");

    sck_idle_a: assert property (
        ((st_ff.mstate == M_IDLE) && $past(st_ff.mstate == M_IDLE) && $stable(st_ff.clock_polarity))
        |-> (sck_out == st_ff.clock_polarity))
        else $error("sck not at idle level");

endmodule : spim_port

`default_nettype wire

//--- test/spim_far_slave.sv
/*
 * Far-side slave model for master transfers of the serial port.
 * Assumes the bench holds sel, mode and tx_byte steady within a frame.
 */
`default_nettype none
module spim_far_slave
(
    // link pins
    input wire logic sel,
    input wire logic clock_polarity,
    input wire logic clock_phase,
    input wire logic sck,
    input wire logic mosi,
    output logic miso,
    // byte side
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte
);
    timeunit 1ns;
    timeprecision 1ns;
    int ncap = 0;
    initial miso = 1'b0;
    // released line shows the inverse, so a stale bit never passes
    always @(negedge sel)
        miso = ~miso;
    always @(posedge sel)
    begin
        ncap = 0;
        miso = tx_byte[7];
    end
    always @(sck)
        if (sel && ((sck != clock_polarity) ^ clock_phase))
        begin
            rx_byte = {rx_byte[6:0], mosi};
            ncap++;
        end
        else if (sel && ncap < 8)
            miso = tx_byte[7 - ncap];
endmodule : spim_far_slave
`default_nettype wire

//--- test/spim_port_tb.sv
/*
 * Bench for the serial port: mode fault, master transfers, slave overrun.
 * Assumes the package, port, fifo and far-slave model are compiled first.
 */
`default_nettype none
module spim_port_tb;
    import spim_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, arst_n, cr_wr, csr_rd, csr_wr, dr_rd, dr_wr, cpu_irq_mask, ss_n_pin, rx_ready;
    logic sck_in, sck_out, sck_oe, mosi_in, mosi_out, mosi_oe, miso_in, miso_out, miso_oe;
    logic irq_req, rx_valid, sel, pol, pha;
    logic [7:0] cr_wdata, csr_wdata, dr_wdata, cr_rdata, csr_rdata, dr_rdata, rx_data;
    logic [7:0] fs_rx, d, f, q, exp_q[$];
    int num_errors = 0, comparisons = 0, cyc = 0, n;
    int halves[5] = '{4, 8, 16, 32, 64};
    logic [2:0] rates[5] = '{3'h0, 3'h1, 3'h6, 3'h2, 3'h3};
    spim_port u_spim_port (.clk, .arst_n, .cr_wr, .cr_wdata, .cr_rdata, .csr_rd, .csr_wr,
        .csr_wdata, .csr_rdata, .dr_rd, .dr_wr, .dr_wdata, .dr_rdata, .cpu_irq_mask, .irq_req,
        .ss_n_pin, .sck_in, .sck_out, .sck_oe, .mosi_in, .mosi_out, .mosi_oe, .miso_in,
        .miso_out, .miso_oe, .rx_valid, .rx_data, .rx_ready);
    spim_far_slave u_spim_far_slave (.sel(sel), .clock_polarity(pol), .clock_phase(pha), .sck(sck_out),
        .mosi(mosi_out), .miso(miso_in), .tx_byte(f), .rx_byte(fs_rx));
    ////////////////////////////////////////
    initial
    begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // k: 0 cr_wr, 1 csr_wr, 2 dr_wr, 3 csr_rd, 4 dr_rd; one-cycle strobe
    task automatic acc(input int k, input logic [7:0] v);
        @(posedge clk);
        #1;
        {cr_wdata, csr_wdata, dr_wdata} = {v, v, v};
        {cr_wr, csr_wr, dr_wr, csr_rd, dr_rd} = 5'b10000 >> k;
        @(posedge clk);
        #1;
        {cr_wr, csr_wr, dr_wr, csr_rd, dr_rd} = 5'b00000;
    endtask : acc
    // one slave byte at the 320 ns link rate, phase one, idle low
    task automatic sbyte(input logic [7:0] m);
        for (int i = 7; i >= 0; i--)
        begin
            mosi_in = m[i];
            sck_in = 1;
            #150;
            q = {q[6:0], miso_out};
            #10;
            sck_in = 0;
            #160;
        end
    endtask : sbyte
    task automatic summarize();
        $display("num_errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    ////////////////////////////////////////
    always @(posedge clk)
    begin
        cyc++;
        if (cyc > 10000)
        begin
            num_errors++;
            summarize();
        end
        else
        begin
            #1;
            rx_ready = 1'($urandom);
        end
    end
    always @(negedge clk)
        if (rx_valid === 1'b1 && rx_ready === 1'b1)
            chk("stream", exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx, rx_data);
    initial
    begin
        {cr_wr, csr_wr, dr_wr, csr_rd, dr_rd, cpu_irq_mask, sel, pol, pha} = '0;
        {sck_in, mosi_in, rx_ready, arst_n, ss_n_pin} = 5'b00001;
        {cr_wdata, csr_wdata, dr_wdata, f} = '0;
        void'($urandom(32'ha6fe_ecee));
        repeat (12) @(posedge clk);
        #1;
        arst_n = 1;
        acc(1, 8'h00);
        acc(0, 8'h80);
        ss_n_pin = 0;
        acc(0, 8'hd0);
        repeat (4) @(posedge clk);
        #1;
        ss_n_pin = 1;
        repeat (4) @(negedge clk);
        chk("csr", 8'h10, csr_rdata);
        chk("cr", 8'h80, cr_rdata);
        chk("irq", 8'h01, {7'h0, irq_req});
        acc(0, 8'hd0);
        repeat (2) @(negedge clk);
        chk("cr", 8'h80, cr_rdata);
        acc(3, 8'h00);
        acc(0, 8'hd0);
        @(negedge clk);
        chk("csr", 8'h00, csr_rdata);
        chk("cr", 8'hd0, cr_rdata);
        $display("test mode fault done");
        for (int i = 0; i < 5; i++)
        begin
            d = $urandom;
            f = $urandom;
            {pol, pha, cpu_irq_mask} = {i[0], i[1], i[0]};
            exp_q.push_back(f);
            acc(0, {2'b10, rates[i][2], 1'b0, pol, pha, rates[i][1:0]});
            acc(1, 8'h03);
            ss_n_pin = 1'($urandom);
            acc(0, {2'b11, rates[i][2], 1'b1, pol, pha, rates[i][1:0]});
            @(negedge clk);
            chk("idle", {7'h0, pol}, {7'h0, sck_out});
            chk("oe", 8'h06, {5'h0, sck_oe, mosi_oe, miso_oe});
            // select the model only now, so polarity changes are not seen as edges
            sel = 1;
            acc(2, d);
            repeat (500) if (sck_out === pol) @(negedge clk);
            n = 0;
            while (sck_out !== pol && n < 500)
            begin
                @(negedge clk);
                n++;
            end
            chk("half", 8'(halves[i]), 8'(n));
            acc(2, ~d);
            repeat (3000) if (csr_rdata[7] !== 1'b1) @(negedge clk);
            chk("tx", d, fs_rx);
            chk("rx", f, dr_rdata);
            chk("csr", 8'hc3, csr_rdata);
            chk("irq", {7'h0, ~cpu_irq_mask}, {7'h0, irq_req});
            acc(2, d);
            repeat (halves[i] + 4) @(negedge clk);
            chk("idle", {7'h0, pol}, {7'h0, sck_out});
            acc(3, 8'h00);
            acc(4, 8'h00);
            @(negedge clk);
            chk("csr", 8'h03, csr_rdata);
            sel = 0;
            $display("test master transfer %0d done", i);
        end
        acc(0, 8'h04);
        acc(1, 8'h02);
        acc(0, 8'h44);
        d = $urandom;
        f = $urandom;
        exp_q.push_back(f);
        exp_q.push_back(~f);
        acc(2, d);
        sbyte(f);
        repeat (6) @(negedge clk);
        chk("slave tx", d, q);
        chk("csr", 8'h82, csr_rdata);
        chk("oe", 8'h01, {5'h0, sck_oe, mosi_oe, miso_oe});
        sbyte(~f);
        repeat (6) @(negedge clk);
        chk("csr", 8'ha2, csr_rdata);
        chk("rx", f, dr_rdata);
        acc(3, 8'h00);
        @(negedge clk);
        chk("csr", 8'h82, csr_rdata);
        $display("test slave overrun done");
        acc(4, 8'h00);
        acc(0, 8'h00);
        acc(0, 8'h40);
        f = $urandom;
        exp_q.push_back(f);
        acc(2, d);
        @(negedge clk);
        chk("csr", 8'h42, csr_rdata);
        acc(1, 8'h03);
        acc(2, ~d);
        acc(1, 8'h02);
        sbyte(f);
        repeat (6) @(negedge clk);
        chk("slave tx", ~d, q);
        chk("rx", f, dr_rdata);
        chk("csr", 8'hc2, csr_rdata);
        repeat (100) @(negedge clk);
        chk("left", 8'h00, 8'(exp_q.size()));
        $display("test slave phase zero done");
        summarize();
    end
endmodule : spim_port_tb
`default_nettype wire
